// *** hw/ccu_pkg.sv ***
package ccu_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CCU_OFF_CTRL = 8'h00;
  localparam logic [7:0] CCU_OFF_PAIR = 8'h04;
  localparam logic [7:0] CCU_OFF_FLAG = 8'h08;
  localparam logic [7:0] CCU_OFF_PORT = 8'h0c;
  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int CCU_MODE_LSB = 0;
  localparam int CCU_DUTY_LSB = 4;
  localparam int CCU_CFG_LSB = 6;
  localparam int CCU_PORT_LATCH_BIT = 0;
  localparam int CCU_PORT_DIR_BIT = 1;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CCU_CTRL_RST = 8'h00;
  localparam logic [15:0] CCU_PAIR_RST = 16'h0000;
  localparam logic CCU_DIR_RST = 1'b1;
  localparam logic CCU_LATCH_RST = 1'b0;
  // ----------------------------------------------------------------
  // mode, output-config and prescaler terminal codes
  // ----------------------------------------------------------------
  localparam logic [3:0] CCU_M_OFF = 4'h0;
  localparam logic [3:0] CCU_M_RSV1 = 4'h1;
  localparam logic [3:0] CCU_M_CMP_TOG = 4'h2;
  localparam logic [3:0] CCU_M_RSV3 = 4'h3;
  localparam logic [3:0] CCU_M_CAP_FALL = 4'h4;
  localparam logic [3:0] CCU_M_CAP_RISE = 4'h5;
  localparam logic [3:0] CCU_M_CAP_DIV4 = 4'h6;
  localparam logic [3:0] CCU_M_CAP_DIV16 = 4'h7;
  localparam logic [3:0] CCU_M_CMP_SET = 4'h8;
  localparam logic [3:0] CCU_M_CMP_CLR = 4'h9;
  localparam logic [3:0] CCU_M_CMP_SWI = 4'ha;
  localparam logic [3:0] CCU_M_CMP_SPEV = 4'hb;
  localparam logic [1:0] CCU_PWM_HI = 2'h3;
  localparam logic [1:0] CCU_CFG_SINGLE = 2'h0;
  localparam logic [1:0] CCU_CFG_FWD = 2'h1;
  localparam logic [1:0] CCU_CFG_HALF = 2'h2;
  localparam logic [1:0] CCU_CFG_REV = 2'h3;
  localparam logic [3:0] CCU_DIV4_LAST = 4'h3;
  localparam logic [3:0] CCU_DIV16_LAST = 4'hf;

  typedef enum logic [1:0] {CCU_FN_NONE, CCU_FN_CAPTURE, CCU_FN_COMPARE, CCU_FN_PWM} ccu_func_t;

  typedef struct packed {
    logic [3:0] own;
    logic [3:0] level;
  } ccu_pins_t;
endpackage : ccu_pkg

// *** hw/ccu_sync.sv ***
`timescale 1ns/1ps
module ccu_sync (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // level
  input wire logic d_in,
  output logic q_out
);
  logic meta_ff;
  logic sync_ff;
  logic nxt_meta;
  logic nxt_sync;

  always_comb begin
    nxt_meta = d_in;
    nxt_sync = meta_ff;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign q_out = sync_ff;
endmodule : ccu_sync

// *** hw/ccu_prescale.sv ***
`timescale 1ns/1ps
module ccu_prescale import ccu_pkg::*; #(
  parameter int CNT_W = 4
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // control
  input wire logic clear_in,
  input wire logic [3:0] mode_in,
  input wire logic rise_in,
  input wire logic fall_in,
  // result
  output logic event_out,
  output logic [CNT_W-1:0] count_out
);
  // elaboration-time refusal of a counter too narrow for divide by 16
  if (CNT_W < 4) begin : g_cnt_w_chk
    $error("ccu_prescale: CNT_W must be at least 4");
  end

  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;

  // count survives a switch between capture settings [RULE9]
  always_comb begin
    nxt_cnt = cnt_ff;
    if (clear_in) begin
      nxt_cnt = '0;
    end else if (rise_in) begin
      nxt_cnt = cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_ff <= '0; // [RULE8]
    end else begin
      cnt_ff <= nxt_cnt; // [RULE7]
    end
  end

  always_comb begin
    event_out = 1'b0;
    case (mode_in)
      CCU_M_CAP_FALL: event_out = fall_in; // [RULE2]
      CCU_M_CAP_RISE: event_out = rise_in;
      CCU_M_CAP_DIV4: event_out = rise_in && (cnt_ff[1:0] == CCU_DIV4_LAST[1:0]);
      CCU_M_CAP_DIV16: event_out = rise_in && (cnt_ff[3:0] == CCU_DIV16_LAST);
      default: event_out = 1'b0;
    endcase
  end

  assign count_out = cnt_ff;
endmodule : ccu_prescale

// *** hw/ccu_top.sv ***
// Function
// RULE1 - mode zero turns unit off, resets it
// RULE2 - capture on fall, rise, 4th, 16th rise
// RULE3 - capture copies full 16-bit timer value
// RULE4 - capture sets flag; only software clears
// RULE5 - new capture overwrites stored value silently
// RULE6 - port latch write can trigger capture
// RULE7 - prescaler cleared outside capture modes
// RULE8 - every reset clears prescaler counter
// RULE9 - prescale switch keeps count, may false-capture
// RULE10 - software keeps irq off, clears flag after change
// RULE11 - timer must run synchronous for capture
// RULE12 - software makes capture pin an input
// RULE13 - compare toggle, set, clear; set flag
// RULE14 - mode 1010 sets flag, pin untouched
// RULE15 - mode 1011 flag, timer reset, conversion
// RULE16 - PWM codes, low bits give polarities
// RULE17 - non-PWM: A is pin, B-D port
// RULE18 - output_config selects PWM output arrangement
// RULE19 - duty_low_bits are PWM duty LSBs only
// RULE20 - reserved codes select no function
// RULE21 - pin synchronised, edges from samples
// RULE22 - control register resets to zero
`timescale 1ns/1ps
module ccu_top import ccu_pkg::*; #(
  parameter int CNT_W = 4
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic pready_out,
  output logic pslverr_out,
  output logic [31:0] prdata_out,
  // timer and converter
  input wire logic [15:0] timer1_count_in,
  input wire logic adc_enable_in,
  output logic timer1_reset_out,
  output logic adc_start_out,
  // pwm generator
  input wire logic pwm_mod_in,
  output logic [9:0] duty_value_out,
  // pins and flag
  input wire logic capture_pin_in,
  output ccu_pins_t pins_out,
  output logic capture_flag_out
);
  // elaboration-time refusal of a counter too narrow for divide by 16
  if (CNT_W < 4) begin : g_cnt_w_chk
    $error("ccu_top: CNT_W must be at least 4");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] ctrl_ff;
  logic [15:0] pair_ff;
  logic flag_ff;
  logic latch_ff;
  logic dir_in_ff;
  logic [31:0] prdata_ff;
  logic cmp_ff;
  logic eq_prev_ff;
  logic lvl_prev_ff;
  ccu_pins_t pins_ff;
  logic tmr_rst_ff;
  logic adc_ff;
  logic [9:0] duty_ff;
  logic [7:0] nxt_ctrl;
  logic [15:0] nxt_pair;
  logic nxt_flag;
  logic nxt_latch;
  logic nxt_dir_in;
  logic [31:0] nxt_prdata;
  logic nxt_cmp;
  logic nxt_eq_prev;
  logic nxt_lvl_prev;
  ccu_pins_t nxt_pins;
  logic nxt_tmr_rst;
  logic nxt_adc;
  logic [9:0] nxt_duty;

  logic [3:0] mode;
  logic [1:0] cfg;
  ccu_func_t func;
  logic wr_en;
  logic rd_setup;
  logic mapped;
  logic pin_sync;
  logic pin_lvl;
  logic rise;
  logic fall;
  logic cap_evt;
  logic [CNT_W-1:0] pre_cnt;
  logic eq;
  logic match;
  logic cmp_drive;
  logic pol_ac;
  logic pol_bd;
  logic mod_ac;
  logic mod_bd;

  assign mode = ctrl_ff[CCU_MODE_LSB +: 4];
  assign cfg = ctrl_ff[CCU_CFG_LSB +: 2];
  assign pol_ac = mode[1]; // [RULE16]
  assign pol_bd = mode[0];

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  always_comb begin
    func = CCU_FN_NONE;
    case (mode)
      CCU_M_OFF, CCU_M_RSV1, CCU_M_RSV3: func = CCU_FN_NONE; // [RULE1] [RULE20]
      CCU_M_CAP_FALL, CCU_M_CAP_RISE, CCU_M_CAP_DIV4, CCU_M_CAP_DIV16: func = CCU_FN_CAPTURE;
      CCU_M_CMP_TOG, CCU_M_CMP_SET, CCU_M_CMP_CLR, CCU_M_CMP_SWI, CCU_M_CMP_SPEV: begin
        func = CCU_FN_COMPARE;
      end
      default: func = CCU_FN_PWM; // [RULE16]
    endcase
  end

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  always_comb begin
    if (paddr_in == CCU_OFF_CTRL) begin
      mapped = 1'b1;
    end else if (paddr_in == CCU_OFF_PAIR) begin
      mapped = 1'b1;
    end else if (paddr_in == CCU_OFF_FLAG) begin
      mapped = 1'b1;
    end else if (paddr_in == CCU_OFF_PORT) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  end

  assign pready_out = 1'b1;
  assign pslverr_out = psel_in && penable_in && !mapped;
  assign wr_en = psel_in && penable_in && pwrite_in && mapped;
  assign rd_setup = psel_in && !penable_in;
  assign prdata_out = prdata_ff;

  // ----------------------------------------------------------------
  // capture input path
  // ----------------------------------------------------------------
  ccu_sync u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .d_in(capture_pin_in),
    .q_out(pin_sync)
  );

  // an output-driven pin sees its own latch [RULE6] [RULE12]
  assign pin_lvl = dir_in_ff ? pin_sync : latch_ff;
  assign rise = pin_lvl && !lvl_prev_ff; // [RULE21]
  assign fall = !pin_lvl && lvl_prev_ff;

  ccu_prescale #(.CNT_W(CNT_W)) u_pre (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .clear_in(func != CCU_FN_CAPTURE), // [RULE7]
    .mode_in(mode),
    .rise_in(rise),
    .fall_in(fall),
    .event_out(cap_evt),
    .count_out(pre_cnt)
  );

  // ----------------------------------------------------------------
  // compare match
  // ----------------------------------------------------------------
  assign eq = (func == CCU_FN_COMPARE) && (timer1_count_in == pair_ff);
  assign match = eq && !eq_prev_ff;
  assign cmp_drive = (mode == CCU_M_CMP_TOG) || (mode == CCU_M_CMP_SET) ||
                     (mode == CCU_M_CMP_CLR);

  // ----------------------------------------------------------------
  // register next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_pair = pair_ff;
    nxt_flag = flag_ff;
    nxt_latch = latch_ff;
    nxt_dir_in = dir_in_ff;
    nxt_prdata = prdata_ff;
    if (rd_setup) begin
      if (paddr_in == CCU_OFF_CTRL) begin
        nxt_prdata = {24'h000000, ctrl_ff};
      end else if (paddr_in == CCU_OFF_PAIR) begin
        nxt_prdata = {16'h0000, pair_ff};
      end else if (paddr_in == CCU_OFF_FLAG) begin
        nxt_prdata = {31'h00000000, flag_ff};
      end else if (paddr_in == CCU_OFF_PORT) begin
        nxt_prdata = {30'h00000000, dir_in_ff, latch_ff};
      end else begin
        nxt_prdata = 32'h00000000;
      end
    end
    if (wr_en) begin
      if (paddr_in == CCU_OFF_CTRL) begin
        nxt_ctrl = pwdata_in[7:0];
      end else if (paddr_in == CCU_OFF_PAIR) begin
        nxt_pair = pwdata_in[15:0];
      end else if (paddr_in == CCU_OFF_FLAG) begin
        if (pwdata_in[0]) begin
          nxt_flag = 1'b0;
        end
      end else if (paddr_in == CCU_OFF_PORT) begin
        nxt_latch = pwdata_in[CCU_PORT_LATCH_BIT];
        nxt_dir_in = pwdata_in[CCU_PORT_DIR_BIT];
      end
    end
    // hardware events win over software writes and clears
    if (cap_evt) begin
      nxt_pair = timer1_count_in; // [RULE3] [RULE5]
      nxt_flag = 1'b1; // [RULE4]
    end
    if (match) begin
      nxt_flag = 1'b1; // [RULE13] [RULE14] [RULE15]
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ctrl_ff <= CCU_CTRL_RST; // [RULE22]
      pair_ff <= CCU_PAIR_RST;
      flag_ff <= 1'b0;
      latch_ff <= CCU_LATCH_RST;
      dir_in_ff <= CCU_DIR_RST;
      prdata_ff <= 32'h00000000;
    end else begin
      ctrl_ff <= nxt_ctrl;
      pair_ff <= nxt_pair;
      flag_ff <= nxt_flag;
      latch_ff <= nxt_latch;
      dir_in_ff <= nxt_dir_in;
      prdata_ff <= nxt_prdata;
    end
  end

  // ----------------------------------------------------------------
  // output logic next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_cmp = cmp_ff;
    nxt_eq_prev = eq;
    nxt_lvl_prev = pin_lvl;
    nxt_tmr_rst = match && (mode == CCU_M_CMP_SPEV); // [RULE15]
    nxt_adc = match && (mode == CCU_M_CMP_SPEV) && adc_enable_in;
    nxt_duty = 10'h000;
    nxt_pins.own = 4'h0;
    nxt_pins.level = {3'h0, latch_ff};
    mod_ac = pwm_mod_in ^ pol_ac;
    mod_bd = pwm_mod_in ^ pol_bd;
    if (mode == CCU_M_OFF) begin
      nxt_cmp = 1'b0; // [RULE1]
    end else if (match) begin
      case (mode)
        CCU_M_CMP_TOG: nxt_cmp = !cmp_ff; // [RULE13]
        CCU_M_CMP_SET: nxt_cmp = 1'b1;
        CCU_M_CMP_CLR: nxt_cmp = 1'b0;
        default: nxt_cmp = cmp_ff; // [RULE14]
      endcase
    end
    if (mode[3:2] != CCU_PWM_HI) begin
      // only output_a may belong to the unit here [RULE17]
      if (cmp_drive) begin
        nxt_pins.own = 4'h1;
        nxt_pins.level = {3'h0, cmp_ff};
      end
    end else begin
      nxt_duty = {pair_ff[7:0], ctrl_ff[CCU_DUTY_LSB +: 2]}; // [RULE19]
      case (cfg) // [RULE18]
        CCU_CFG_SINGLE: begin
          nxt_pins.own = 4'h1;
          nxt_pins.level = {3'h0, mod_ac};
        end
        CCU_CFG_FWD: begin
          nxt_pins.own = 4'hf;
          nxt_pins.level = {mod_bd, pol_ac, pol_bd, !pol_ac};
        end
        CCU_CFG_HALF: begin
          nxt_pins.own = 4'h3;
          nxt_pins.level = {2'h0, !pwm_mod_in ^ pol_bd, mod_ac};
        end
        default: begin
          nxt_pins.own = 4'hf;
          nxt_pins.level = {pol_bd, !pol_ac, mod_bd, pol_ac};
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cmp_ff <= 1'b0;
      eq_prev_ff <= 1'b0;
      lvl_prev_ff <= 1'b0;
      pins_ff <= '0;
      tmr_rst_ff <= 1'b0;
      adc_ff <= 1'b0;
      duty_ff <= 10'h000;
    end else begin
      cmp_ff <= nxt_cmp;
      eq_prev_ff <= nxt_eq_prev;
      lvl_prev_ff <= nxt_lvl_prev;
      pins_ff <= nxt_pins;
      tmr_rst_ff <= nxt_tmr_rst;
      adc_ff <= nxt_adc;
      duty_ff <= nxt_duty;
    end
  end

  assign pins_out = pins_ff;
  assign timer1_reset_out = tmr_rst_ff;
  assign adc_start_out = adc_ff;
  assign duty_value_out = duty_ff;
  assign capture_flag_out = flag_ff;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  logic flag_clr;
  assign flag_clr = wr_en && (paddr_in == CCU_OFF_FLAG) && pwdata_in[0];

  property p_off_state;
    @(posedge clk_in) disable iff (rst_in)
      (mode == CCU_M_OFF) ##1 (mode == CCU_M_OFF) |-> (cmp_ff == 1'b0) && (pins_ff.own == 4'h0);
  endproperty
  a_off_state: assert property (p_off_state) else $error("unit off but still active"); // [RULE1]

  property p_fall_evt;
    @(posedge clk_in) disable iff (rst_in)
      (mode == CCU_M_CAP_FALL) && fall |-> cap_evt;
  endproperty
  a_fall_evt: assert property (p_fall_evt) else $error("falling edge not captured"); // [RULE2]

  property p_div4;
    @(posedge clk_in) disable iff (rst_in)
      (mode == CCU_M_CAP_DIV4) && cap_evt |-> (pre_cnt[1:0] == 2'h3) && rise;
  endproperty
  a_div4: assert property (p_div4) else $error("divide by four capture off count"); // [RULE2]

  property p_copy;
    @(posedge clk_in) disable iff (rst_in)
      cap_evt |=> (pair_ff == $past(timer1_count_in)) && flag_ff;
  endproperty
  a_copy: assert property (p_copy) else $error("capture value or flag wrong"); // [RULE3]

  property p_flag_sticky;
    @(posedge clk_in) disable iff (rst_in)
      flag_ff && !flag_clr |=> flag_ff;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped by hardware"); // [RULE4]

  property p_pre_clear;
    @(posedge clk_in) disable iff (rst_in)
      (func != CCU_FN_CAPTURE) |=> (pre_cnt == '0);
  endproperty
  a_pre_clear: assert property (p_pre_clear) else $error("prescaler not cleared"); // [RULE7]

  property p_reset_clear;
    @(posedge clk_in) rst_in |=> (pre_cnt == '0) && (ctrl_ff == CCU_CTRL_RST);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset left state"); // [RULE8]

  property p_spev;
    @(posedge clk_in) disable iff (rst_in)
      match && (mode == CCU_M_CMP_SPEV) |=> timer1_reset_out && flag_ff &&
        (adc_start_out == $past(adc_enable_in));
  endproperty
  a_spev: assert property (p_spev) else $error("special event missing"); // [RULE15]

  property p_swi_pin;
    @(posedge clk_in) disable iff (rst_in)
      (mode == CCU_M_CMP_SWI) |=> (pins_ff.own == 4'h0);
  endproperty
  a_swi_pin: assert property (p_swi_pin) else $error("pin driven in soft interrupt mode"); // [RULE14]

  property p_bcd_port;
    @(posedge clk_in) disable iff (rst_in)
      (mode[3:2] != CCU_PWM_HI) |=> (pins_ff.own[3:1] == 3'h0) && (duty_value_out == 10'h000);
  endproperty
  a_bcd_port: assert property (p_bcd_port) else $error("b-d taken outside pwm"); // [RULE17] [RULE19]

  c_capture: cover property (@(posedge clk_in) disable iff (rst_in) cap_evt);
  c_div16: cover property (@(posedge clk_in) disable iff (rst_in)
    cap_evt && (mode == CCU_M_CAP_DIV16));
  c_match: cover property (@(posedge clk_in) disable iff (rst_in) match && cmp_drive);
  c_pwm: cover property (@(posedge clk_in) disable iff (rst_in) func == CCU_FN_PWM);
endmodule : ccu_top

// *** bench/ccu_pin_src.sv ***
`timescale 1ns/1ps
module ccu_pin_src (
  // clock
  input wire logic clk_in,
  // capture pin drive
  output logic pin_out
);
  // line rests low between pulses, changes only after an edge
  initial pin_out = 1'b0;

  // one pulse, widths in cycles, slow or prompt as asked
  task automatic pulse(input int hi, input int lo);
    pin_out <= 1'b1;
    repeat (hi) @(posedge clk_in);
    pin_out <= 1'b0;
    repeat (lo) @(posedge clk_in);
  endtask : pulse
endmodule : ccu_pin_src

// *** bench/capture_unit_with_mode_control_tb.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; \
  $display("ERROR %0t: got %h expected %h", $time, a, b); end end
module capture_unit_with_mode_control_tb import ccu_pkg::*;;
  // ----------------------------------------------------------------
  // design and partner
  // ----------------------------------------------------------------
  logic clk_in, rst_in, psel, penable, pwrite, pready, pslverr, se;
  logic adc_en, pwm_mod, cap_flag, t1_rst, adc_start, pin, mflag, ml;
  logic [7:0] paddr, mctrl;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] timer, mpair, mp;
  logic [9:0] duty;
  ccu_pins_t pins;
  int errors, total_checks, pc, tmr, nr, na, m, cfg, md, dl;
  int cm[7] = '{8, 2, 2, 9, 10, 11, 11};

  ccu_top #(.CNT_W(4)) ccu_top_i (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .pready_out(pready), .pslverr_out(pslverr), .prdata_out(prdata),
    .timer1_count_in(timer), .adc_enable_in(adc_en), .timer1_reset_out(t1_rst),
    .adc_start_out(adc_start), .pwm_mod_in(pwm_mod), .duty_value_out(duty),
    .capture_pin_in(pin), .pins_out(pins), .capture_flag_out(cap_flag));
  ccu_pin_src ccu_pin_src_i (.clk_in(clk_in), .pin_out(pin));

  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  // ----------------------------------------------------------------
  // bus, model and check tasks
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask : cyc

  // one transfer, then one idle cycle so no signal is set twice at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    @(posedge clk_in);
    while (pready !== 1'b1) @(posedge clk_in);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_in);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    case (a)
      8'h00: begin
        if (!(d[3:0] inside {[4'h4:4'h7]})) pc = 0;
        if (d[3:0] == 4'h0) ml = 1'b0;
        mctrl = d[7:0];
      end
      8'h04: mpair = d[15:0];
      8'h08: if (d[0]) mflag = 1'b0;
      default: ;
    endcase
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask : rdc

  // one pin pulse with a fresh timer value held until it is captured
  task automatic pulse();
    int n;
    tmr = $urandom % 65536;
    timer <= 16'(tmr);
    @(posedge clk_in);
    ccu_pin_src_i.pulse(5 + $urandom % 3, 5 + $urandom % 3);
    n = mctrl[0] ? 16 : 4;
    if (mctrl[3:0] inside {[4'h4:4'h7]}) begin
      if (mctrl[3:1] == 3'h2 || pc % n == n - 1) begin
        mpair = 16'(tmr);
        mflag = 1'b1;
      end
      pc++;
    end
  endtask : pulse

  task automatic chk();
    rdc(8'h04, 32'(mpair));
    rdc(8'h08, 32'(mflag));
    `CHK(cap_flag, mflag)
    `CHK(pins.own[3:1], 3'h0)
    `CHK(duty, 10'h0)
  endtask : chk

  // hold a match for five edges counting pulses, then break it
  task automatic match();
    nr = 0;
    na = 0;
    timer <= mp;
    // pulses are counted mid-cycle, where the outputs have settled
    repeat (5) begin
      @(negedge clk_in);
      nr += int'(t1_rst === 1'b1);
      na += int'(adc_start === 1'b1);
    end
    @(posedge clk_in);
    timer <= mp ^ 16'h1;
    cyc(2);
    mflag = 1'b1;
  endtask : match

  function automatic ccu_pins_t pexp(int m, int cfg, int md);
    logic [3:0] own, lv;
    case (cfg)
      0: begin own = 4'h1; lv = {3'h0, md[0]}; end
      1: begin own = 4'hf; lv = {md[0], 3'h1}; end
      2: begin own = 4'h3; lv = {2'h0, ~md[0], md[0]}; end
      default: begin own = 4'hf; lv = {2'h1, md[0], 1'b0}; end
    endcase
    lv = (lv ^ {m[0], m[1], m[0], m[1]}) & own;
    return {own, lv};
  endfunction : pexp

  task automatic results();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results

  initial begin
    repeat (20000) @(posedge clk_in);
    errors++;
    results();
  end
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    rst_in = 1'b1;
    {psel, penable, pwrite, adc_en, pwm_mod, mflag, ml} = '0;
    {paddr, pwdata, timer, mctrl, mpair} = '0;
    {errors, total_checks, pc} = '0;
    void'($urandom(45));
    cyc(3);
    rst_in <= 1'b0;
    `CHK(pins, 8'h00)
    `CHK(pready, 1'b1)
    rdc(8'h00, 32'h0);
    rdc(8'h0c, 32'h2);
    chk();
    wr(8'h10, 32'hff);
    `CHK(se, 1'b1)
    rdc(8'h10, 32'h0);
    for (int k = 4; k < 8; k++) begin
      wr(8'h00, 32'h0);
      wr(8'h00, k);
      wr(8'h08, 32'h1);
      repeat (k == 7 ? 17 : 5) pulse();
      chk();
    end
    cyc(20);
    `CHK(cap_flag, 1'b1)
    wr(8'h08, 32'h1);
    chk();
    wr(8'h00, 32'h0);
    wr(8'h00, 32'h6);
    repeat (2) pulse();
    wr(8'h00, 32'h7);
    repeat (14) pulse();
    chk();
    wr(8'h00, 32'h6);
    repeat (2) pulse();
    wr(8'h00, 32'hc);
    wr(8'h00, 32'h6);
    repeat (4) pulse();
    chk();
    repeat (2) pulse();
    rst_in <= 1'b1;
    cyc(3);
    rst_in <= 1'b0;
    {mctrl, mpair, mflag, pc, ml} = '0;
    wr(8'h00, 32'h6);
    repeat (4) pulse();
    chk();
    for (int r = 0; r < 4; r += 2) begin
      wr(8'h00, r + 1);
      repeat (2) pulse();
      chk();
      `CHK(pins.own, 4'h0)
    end
    wr(8'h00, 32'h0);
    pulse();
    chk();
    `CHK(pins.own, 4'h0)
    wr(8'h00, 32'h5);
    wr(8'h0c, 32'h0);
    tmr = $urandom % 65536;
    timer <= 16'(tmr);
    wr(8'h08, 32'h1);
    wr(8'h0c, 32'h1);
    cyc(4);
    mpair = 16'(tmr);
    mflag = 1'b1;
    chk();
    wr(8'h0c, 32'h0);
    wr(8'h0c, 32'h2);
    mp = 16'($urandom);
    wr(8'h00, 32'h0);
    timer <= mp ^ 16'h1;
    wr(8'h04, 32'(mp));
    foreach (cm[k]) begin
      adc_en <= (k == 6);
      wr(8'h00, cm[k]);
      wr(8'h08, 32'h1);
      match();
      if (cm[k] == 8) ml = 1'b1;
      if (cm[k] == 9) ml = 1'b0;
      if (cm[k] == 2) ml = ~ml;
      `CHK(pins.level[0], ml)
      `CHK(pins.own[0], 1'(cm[k] < 10))
      rdc(8'h08, 32'h1);
      `CHK(nr, int'(cm[k] == 11))
      `CHK(na, int'(k == 6))
    end
    for (int i = 0; i < 32; i++) begin
      m = 12 + i % 4;
      cfg = (i / 4) % 4;
      md = i / 16;
      dl = $urandom % 4;
      pwm_mod <= md[0];
      wr(8'h00, {24'h0, cfg[1:0], dl[1:0], m[3:0]});
      cyc(2);
      `CHK(pins, pexp(m, cfg, md))
      `CHK(duty, ({mpair[7:0], dl[1:0]}))
    end
    results();
  end
endmodule : capture_unit_with_mode_control_tb
